// file: verilog/pets_top.sv
// Per-input edge timestamp capture with register port, data-set trigger and interrupt
`include "pets_consts.svh"

module pets_top
	import pets_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [31:0] busRdData,
	input wire logic [15:0] pointIn,
	output logic sendDataSet,
	output logic irq
);

	// ----------------------------------------------------------------
	// Registers written by software, their edge history and interrupt status
	// ----------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [15:0] riseEn_r;
	logic [15:0] fallEn_r;
	logic [31:0] ackSel_r;
	logic [15:0] ackStrobe_r;
	logic [15:0] ackPrev_r;
	logic clearPrev_r;
	logic [31:0] interval_r;
	logic [2:0] irqEnable_r;
	logic [2:0] irqStatus_r;

	// ----------------------------------------------------------------
	// Block state
	// ----------------------------------------------------------------
	pets_stamp_t timeNow_r;
	logic [31:0] count_r;
	logic [31:0] rpiCnt_r;
	logic sendDataSet_r;
	logic [31:0] busRdData_r;

	logic [63:0] riseArr [16];
	logic [63:0] fallArr [16];
	logic [15:0] newFlags;
	logic [15:0] lostFlags;
	logic [15:0] riseStampedV;
	logic [15:0] fallStampedV;
	logic [5:0] countInc;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire wrCtrl = busWr & (busAddr == `PETS_OFF_CTRL);
	wire wrRiseEn = busWr & (busAddr == `PETS_OFF_RISE_EN);
	wire wrFallEn = busWr & (busAddr == `PETS_OFF_FALL_EN);
	wire wrAckSel = busWr & (busAddr == `PETS_OFF_ACK_SEL);
	wire wrAckStrobe = busWr & (busAddr == `PETS_OFF_ACK_STROBE);
	wire wrInterval = busWr & (busAddr == `PETS_OFF_INTERVAL);
	wire wrIrqClear = busWr & (busAddr == `PETS_OFF_IRQ_CLEAR);
	wire wrIrqEnable = busWr & (busAddr == `PETS_OFF_IRQ_ENABLE);

	// ----------------------------------------------------------------
	// Control decode
	// ----------------------------------------------------------------
	wire holdFirst = ctrl_r[`PETS_CTRL_HOLD_BIT];
	wire formatFlag = ctrl_r[`PETS_CTRL_FORMAT_BIT];
	wire clearLevel = ctrl_r[`PETS_CTRL_CLEAR_BIT];
	wire clearAll = clearLevel & ~clearPrev_r;
	wire [15:0] ackPulse = ackStrobe_r & ~ackPrev_r;

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : gChan
			pets_channel uChan (
				.clk(clk),
				.sys_rst(sys_rst),
				.pointPin(pointIn[gi]),
				.timeNow(timeNow_r),
				.riseEn(riseEn_r[gi]),
				.fallEn(fallEn_r[gi]),
				.holdFirst(holdFirst),
				.ackPulse(ackPulse[gi]),
				.ackSel(ackSel_r[2*gi+1 -: 2]),
				.clearAll(clearAll),
				.riseStamp(riseArr[gi]),
				.fallStamp(fallArr[gi]),
				.newFlag(newFlags[gi]),
				.lostFlag(lostFlags[gi]),
				.riseStamped(riseStampedV[gi]),
				.fallStamped(fallStampedV[gi])
			);
		end
	endgenerate

	// Number of stamps taken in this cycle
	always_comb begin
		countInc = 6'h00;
		for (int i = 0; i < 16; i++) begin
			countInc = countInc + 6'(riseStampedV[i]) + 6'(fallStampedV[i]);
		end
	end

	wire anyStamped = |{riseStampedV, fallStampedV};
	wire anyLost = |lostFlags;
	wire rpiHit = (interval_r == 32'h0000_0000) | (rpiCnt_r >= (interval_r - 32'h0000_0001));

	// ----------------------------------------------------------------
	// Interrupt events
	// ----------------------------------------------------------------
	wire [2:0] irqEvents = {rpiHit | anyStamped, anyLost, anyStamped};
	wire [2:0] irqClearMask = wrIrqClear ? busWrData[2:0] : 3'h0;
	wire [2:0] irqStatus_nxt = irqEvents | (irqStatus_r & ~irqClearMask);

	// ----------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------
	wire inStampPage = (busAddr[11:8] == `PETS_STAMP_PAGE);
	wire [3:0] stampIdx = busAddr[7:4];
	wire [1:0] stampWord = busAddr[3:2];
	wire [63:0] riseSel = riseArr[stampIdx];
	wire [63:0] fallSel = fallArr[stampIdx];
	wire [31:0] stampRd = (stampWord == 2'h0) ? riseSel[31:0] :
		(stampWord == 2'h1) ? riseSel[63:32] :
		(stampWord == 2'h2) ? fallSel[31:0] : fallSel[63:32];
	wire [31:0] regRd =
		(busAddr == `PETS_OFF_CTRL) ? ctrl_r :
		(busAddr == `PETS_OFF_RISE_EN) ? {16'h0000, riseEn_r} :
		(busAddr == `PETS_OFF_FALL_EN) ? {16'h0000, fallEn_r} :
		(busAddr == `PETS_OFF_ACK_SEL) ? ackSel_r :
		(busAddr == `PETS_OFF_ACK_STROBE) ? {16'h0000, ackStrobe_r} :
		(busAddr == `PETS_OFF_INTERVAL) ? interval_r :
		(busAddr == `PETS_OFF_NEW_FLAGS) ? {16'h0000, newFlags} :
		(busAddr == `PETS_OFF_LOST_FLAGS) ? {16'h0000, lostFlags} :
		(busAddr == `PETS_OFF_FORMAT) ? {31'h0000_0000, formatFlag} :
		(busAddr == `PETS_OFF_COUNT) ? count_r :
		(busAddr == `PETS_OFF_IRQ_STATUS) ? {29'h0000_0000, irqStatus_r} :
		(busAddr == `PETS_OFF_IRQ_ENABLE) ? {29'h0000_0000, irqEnable_r} : 32'h0000_0000;
	wire [31:0] rdSel = inStampPage ? stampRd : regRd;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_r <= `PETS_CTRL_RESET;
			riseEn_r <= `PETS_EN_RESET;
			fallEn_r <= `PETS_EN_RESET;
			ackSel_r <= 32'h0000_0000;
			ackStrobe_r <= 16'h0000;
			interval_r <= `PETS_INTERVAL_RESET;
			irqEnable_r <= 3'h0;
		end else begin
			if (wrCtrl) begin
				ctrl_r <= {29'h0000_0000, busWrData[2:0]};
			end
			if (wrRiseEn) begin
				riseEn_r <= busWrData[15:0];
			end
			if (wrFallEn) begin
				fallEn_r <= busWrData[15:0];
			end
			if (wrAckSel) begin
				ackSel_r <= busWrData;
			end
			if (wrAckStrobe) begin
				ackStrobe_r <= busWrData[15:0];
			end
			if (wrInterval) begin
				interval_r <= busWrData;
			end
			if (wrIrqEnable) begin
				irqEnable_r <= busWrData[2:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Strobe edge history
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ackPrev_r <= 16'h0000;
			clearPrev_r <= 1'b0;
		end else begin
			ackPrev_r <= ackStrobe_r;
			clearPrev_r <= clearLevel;
		end
	end

	// ----------------------------------------------------------------
	// Time base, transition count, packet interval
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			timeNow_r <= 64'h0000_0000_0000_0000;
		end else begin
			timeNow_r <= timeNow_r + 64'h0000_0000_0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst | clearAll) begin
			count_r <= 32'h0000_0000;
		end else begin
			count_r <= count_r + {26'h000_0000, countInc};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rpiCnt_r <= 32'h0000_0000;
			sendDataSet_r <= 1'b0;
		end else begin
			rpiCnt_r <= rpiHit ? 32'h0000_0000 : rpiCnt_r + 32'h0000_0001;
			sendDataSet_r <= anyStamped | rpiHit;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and read port
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irqStatus_r <= 3'h0;
			busRdData_r <= 32'h0000_0000;
		end else begin
			irqStatus_r <= irqStatus_nxt;
			busRdData_r <= busRd ? rdSel : 32'h0000_0000;
		end
	end

	assign busRdData = busRdData_r;
	assign sendDataSet = sendDataSet_r;
	assign irq = |(irqStatus_r & irqEnable_r);

endmodule

// file: include/pets_consts.svh
// Offsets, field positions, reset values and timing counts of the edge stamp block
`ifndef PETS_CONSTS_SVH
`define PETS_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PETS_OFF_CTRL 12'h000
`define PETS_OFF_RISE_EN 12'h004
`define PETS_OFF_FALL_EN 12'h008
`define PETS_OFF_ACK_SEL 12'h00C
`define PETS_OFF_ACK_STROBE 12'h010
`define PETS_OFF_INTERVAL 12'h014
`define PETS_OFF_NEW_FLAGS 12'h018
`define PETS_OFF_LOST_FLAGS 12'h01C
`define PETS_OFF_FORMAT 12'h020
`define PETS_OFF_COUNT 12'h024
`define PETS_OFF_IRQ_STATUS 12'h028
`define PETS_OFF_IRQ_CLEAR 12'h02C
`define PETS_OFF_IRQ_ENABLE 12'h030
`define PETS_STAMP_PAGE 4'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PETS_CTRL_CLEAR_BIT 0
`define PETS_CTRL_HOLD_BIT 1
`define PETS_CTRL_FORMAT_BIT 2
`define PETS_IRQ_STAMP_BIT 0
`define PETS_IRQ_LOST_BIT 1
`define PETS_IRQ_SEND_BIT 2

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define PETS_CTRL_RESET 32'h0000_0002
`define PETS_EN_RESET 16'hFFFF
`define PETS_INTERVAL_RESET 32'h000F_4240

`endif

// file: include/pets_pkg.sv
// Types shared by the edge stamp block
package pets_pkg;

	typedef enum logic [1:0] {
		PETS_ACK_FALL = 2'h0,
		PETS_ACK_RISE = 2'h1,
		PETS_ACK_BOTH = 2'h2
	} pets_ack_sel_t;

	typedef logic [63:0] pets_stamp_t;

endpackage

// file: verilog/pets_channel.sv
// One input: pin synchroniser, edge detection, two stamps and their flags
module pets_channel
	import pets_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pointPin,
	input wire logic [63:0] timeNow,
	input wire logic riseEn,
	input wire logic fallEn,
	input wire logic holdFirst,
	input wire logic ackPulse,
	input wire logic [1:0] ackSel,
	input wire logic clearAll,
	output logic [63:0] riseStamp,
	output logic [63:0] fallStamp,
	output logic newFlag,
	output logic lostFlag,
	output logic riseStamped,
	output logic fallStamped
);

	logic sync1_r, sync2_r, sync3_r, level_r;
	logic riseValid_r, fallValid_r, newFlag_r, lostFlag_r;
	pets_stamp_t riseStamp_r, fallStamp_r;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	wire settled = (sync2_r == sync3_r);
	wire riseEdge = settled & sync3_r & ~level_r;
	wire fallEdge = settled & ~sync3_r & level_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			sync1_r <= pointPin;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (settled) begin
				level_r <= sync3_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Capture and acknowledge
	// ----------------------------------------------------------------
	wire riseEvt = riseEdge & riseEn;
	wire fallEvt = fallEdge & fallEn;
	wire riseKeep = riseEvt & holdFirst & riseValid_r;
	wire fallKeep = fallEvt & holdFirst & fallValid_r;
	wire riseTake = riseEvt & ~riseKeep;
	wire fallTake = fallEvt & ~fallKeep;
	wire ackRise = ackPulse & ((ackSel == PETS_ACK_RISE) | (ackSel == PETS_ACK_BOTH));
	wire ackFall = ackPulse & ((ackSel == PETS_ACK_FALL) | (ackSel == PETS_ACK_BOTH));
	wire riseClr = clearAll | ackRise;
	wire fallClr = clearAll | ackFall;
	wire flagClr = clearAll | ackPulse;
	wire lostHit = (riseEvt & riseValid_r) | (fallEvt & fallValid_r);

	// A capture in the same cycle as a clear wins
	wire [63:0] riseStamp_nxt = riseTake ? timeNow : (riseClr ? 64'h0000_0000_0000_0000 : riseStamp_r);
	wire [63:0] fallStamp_nxt = fallTake ? timeNow : (fallClr ? 64'h0000_0000_0000_0000 : fallStamp_r);
	wire riseValid_nxt = riseTake | (riseValid_r & ~riseClr);
	wire fallValid_nxt = fallTake | (fallValid_r & ~fallClr);
	wire newFlag_nxt = riseTake | fallTake | (newFlag_r & ~flagClr);
	wire lostFlag_nxt = lostHit | (lostFlag_r & ~flagClr);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			riseStamp_r <= 64'h0000_0000_0000_0000;
			fallStamp_r <= 64'h0000_0000_0000_0000;
			riseValid_r <= 1'b0;
			fallValid_r <= 1'b0;
			newFlag_r <= 1'b0;
			lostFlag_r <= 1'b0;
		end else begin
			riseStamp_r <= riseStamp_nxt;
			fallStamp_r <= fallStamp_nxt;
			riseValid_r <= riseValid_nxt;
			fallValid_r <= fallValid_nxt;
			newFlag_r <= newFlag_nxt;
			lostFlag_r <= lostFlag_nxt;
		end
	end

	assign riseStamp = riseStamp_r;
	assign fallStamp = fallStamp_r;
	assign newFlag = newFlag_r;
	assign lostFlag = lostFlag_r;
	assign riseStamped = riseTake;
	assign fallStamped = fallTake;

endmodule

// file: dv/pets_ctl_model.sv
// Controller model: register bus master with acknowledge and clear-all sequences
module pets_ctl_model
	import pets_pkg::*;
(
	input wire logic clk,
	output logic [11:0] busAddr,
	output logic [31:0] busWrData,
	output logic busWr,
	output logic busRd,
	input wire logic [31:0] busRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {busAddr, busWrData, busWr, busRd} = '0;
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		busWr <= 1'b1;
		busAddr <= a;
		busWrData <= d;
		@(posedge clk);
		busWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		busRd <= 1'b1;
		busAddr <= a;
		@(posedge clk);
		busRd <= 1'b0;
		#1 d = busRdData;
	endtask
	// Strobe held low longer than the 1000-cycle interval before the fresh rise
	task automatic ack(input int n, input pets_ack_sel_t s);
		wr(12'h00C, 32'(s) << (2 * n));
		wr(12'h010, 32'h0000_0000);
		repeat (1100) @(posedge clk);
		wr(12'h010, 32'h0000_0001 << n);
	endtask
	task automatic clr;
		wr(12'h000, 32'h0000_0002);
		repeat (1100) @(posedge clk);
		wr(12'h000, 32'h0000_0003);
	endtask
endmodule

// file: dv/pets_top_monitor.sv
// Port checker for the edge stamp block
module pets_top_monitor (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] busAddr,
	input wire logic [31:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [31:0] busRdData,
	input wire logic [15:0] pointIn,
	input wire logic sendDataSet,
	input wire logic irq
);
	logic ctrlLow_r;
	logic [15:0] strobe_r, ackBits_r, pinPrev_r;
	logic [3:0] stbl_r;
	logic [5:0] clrAge_r;
	wire pinSame = pointIn == pinPrev_r;
	wire clrNow = busWr && busAddr == 12'h000 && busWrData[0] && !ctrlLow_r && stbl_r >= 4'h6;
	wire ackNow = busWr && busAddr == 12'h010 && (busWrData[15:0] & ~strobe_r) != 16'h0000;
	// ----
	// Bus shadows and pin quiet time
	// ----
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{ctrlLow_r, strobe_r, ackBits_r, pinPrev_r, stbl_r, clrAge_r} <= '0;
		end else begin
			if (busWr && busAddr == 12'h000) ctrlLow_r <= busWrData[0];
			if (busWr && busAddr == 12'h010) strobe_r <= busWrData[15:0];
			if (ackNow) ackBits_r <= busWrData[15:0] & ~strobe_r;
			pinPrev_r <= pointIn;
			stbl_r <= !pinSame ? 4'h0 : (stbl_r == 4'hF ? stbl_r : stbl_r + 4'h1);
			clrAge_r <= clrNow ? 6'h01 : (!pinSame || busWr || clrAge_r == 6'h00) ? 6'h00 : clrAge_r + 6'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property clrRd(a);
		$past(busRd) && $past(busAddr) == a && clrAge_r > 6'h02 |-> busRdData == 32'h0000_0000;
	endproperty
	property ackRd(a);
		ackNow && stbl_r >= 4'h6 ##2 busRd && busAddr == a && $stable(pointIn)
			|=> (busRdData[15:0] & ackBits_r) == 16'h0000;
	endproperty
	new_upper_a: assert property ($past(busRd) && $past(busAddr) == 12'h018 |-> busRdData[31:16] == 16'h0000)
		else $error("new flag word upper half set");
	lost_upper_a: assert property ($past(busRd) && $past(busAddr) == 12'h01C |-> busRdData[31:16] == 16'h0000)
		else $error("lost flag word upper half set");
	format_bit_a: assert property ($past(busRd) && $past(busAddr) == 12'h020 |-> busRdData[31:1] == 31'h0)
		else $error("format word has extra bits");
	count_clear_a: assert property (clrRd(12'h024))
		else $error("count not cleared");
	new_clear_a: assert property (clrRd(12'h018))
		else $error("new flags not cleared");
	lost_clear_a: assert property (clrRd(12'h01C))
		else $error("lost flags not cleared");
	stamp_clear_a: assert property (clrRd(12'h100))
		else $error("stamp not erased");
	ack_new_a: assert property (ackRd(12'h018))
		else $error("new flag kept after acknowledge");
	ack_lost_a: assert property (ackNow && stbl_r >= 4'h6 ##4 busRd && busAddr == 12'h01C && $stable(pointIn) |=> (busRdData[15:0] & ackBits_r) == 16'h0000)
		else $error("lost flag kept after acknowledge");
	cover property (clrNow);
	cover property (ackNow);
	cover property (sendDataSet);
	cover property (irq);
endmodule
bind pets_top pets_top_monitor MON (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
	.busWr(busWr), .busRd(busRd), .busRdData(busRdData), .pointIn(pointIn), .sendDataSet(sendDataSet), .irq(irq));

// file: dv/tb_top.sv
// Self-checking bench for the edge stamp block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pets_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] pointIn = 16'h0000;
	logic [15:0] lf = 16'h004B;
	logic [11:0] busAddr;
	logic [31:0] busWrData, busRdData, v, cnt, newExp, lostExp;
	logic [31:0] rs[4], fs[4];
	logic busWr, busRd, sendDataSet, irq;
	int n_mismatch = 0;
	int checks_done = 0;
	int ns[4];
	initial forever #2.5 clk = ~clk;
	pets_ctl_model CTL (.clk(clk), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
		.busRdData(busRdData));
	pets_top DUT (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
		.busRd(busRd), .busRdData(busRdData), .pointIn(pointIn), .sendDataSet(sendDataSet), .irq(irq));
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [11:0] sa(input int n, input int k);
		return 12'h100 + 12'(n * 16 + k * 4);
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		CTL.rd(a, d);
		cmp(d, exp);
	endtask
	task automatic irqIs(input logic e);
		@(negedge clk);
		cmp(32'(irq), 32'(e));
	endtask
	// High for exactly dl cycles, then quiet
	task automatic hit(input int i, input int dl, input int mode);
		logic [31:0] r, f;
		@(posedge clk) pointIn[ns[i]] <= 1'b1;
		// Send pulse stands in the cycle after the detect edge, four edges on
		repeat (5) @(negedge clk);
		if (mode != 1) cmp(32'(sendDataSet), 32'h0000_0001);
		repeat (dl - 4) @(posedge clk);
		pointIn[ns[i]] <= 1'b0;
		repeat (12) @(posedge clk);
		CTL.rd(sa(ns[i], 0), r);
		CTL.rd(sa(ns[i], 2), f);
		if (mode == 1) begin
			cmp(r, rs[i]);
			cmp(f, fs[i]);
		end else begin
			cmp(f - r, 32'(dl));
			cmp(32'(r > rs[i]), 32'h0000_0001);
			cnt += 2;
		end
		if (mode > 0) lostExp[ns[i]] = 1'b1;
		newExp[ns[i]] = 1'b1;
		rs[i] = r;
		fs[i] = f;
		chk(sa(ns[i], 3), 32'h0000_0000);
		chk(12'h024, cnt);
		chk(12'h018, newExp);
		chk(12'h01C, lostExp);
	endtask
	task automatic results;
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{cnt, newExp, lostExp} = '0;
		rs = '{default: '0};
		fs = '{default: '0};
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(12'h000, 32'h0000_0002);
		chk(12'h008, 32'h0000_FFFF);
		chk(12'h014, 32'h000F_4240);
		chk(12'h030, 32'h0000_0000);
		chk(12'h034, 32'h0000_0000);
		CTL.wr(12'h014, 32'h0000_0014);
		repeat (20) @(posedge clk);
		v = '0;
		repeat (200) @(negedge clk) v += 32'(sendDataSet);
		cmp(v, 32'h0000_000A);
		CTL.wr(12'h014, 32'h0000_03E8);
		CTL.wr(12'h030, 32'h0000_0001);
		repeat (40) @(posedge clk);
		for (int i = 0; i < 4; i++) begin
			lf = step(lf);
			ns[i] = i * 5;
			hit(i, 10 + int'(lf[3:0]), 0);
		end
		hit(3, 12, 1);
		CTL.wr(12'h000, 32'h0000_0000);
		lf = step(lf);
		hit(3, 10 + int'(lf[3:0]), 2);
		irqIs(1'b1);
		CTL.wr(12'h030, 32'h0000_0000);
		irqIs(1'b0);
		CTL.wr(12'h030, 32'h0000_0001);
		CTL.wr(12'h02C, 32'h0000_0001);
		irqIs(1'b0);
		for (int i = 0; i < 4; i++) begin
			CTL.ack(ns[i], i == 3 ? PETS_ACK_BOTH : pets_ack_sel_t'(i));
			newExp[ns[i]] = 1'b0;
			lostExp[ns[i]] = 1'b0;
			chk(12'h018, newExp);
			chk(12'h01C, lostExp);
			chk(sa(ns[i], 0), i == 0 ? rs[i] : 32'h0000_0000);
			chk(sa(ns[i], 2), i == 1 ? fs[i] : 32'h0000_0000);
		end
		rs[2] = '0;
		hit(2, 12, 0);
		hit(2, 14, 2);
		CTL.clr();
		chk(12'h024, 32'h0000_0000);
		chk(12'h018, 32'h0000_0000);
		chk(12'h01C, 32'h0000_0000);
		chk(12'h100, 32'h0000_0000);
		{cnt, newExp, lostExp} = '0;
		rs = '{default: '0};
		hit(0, 11, 0);
		CTL.wr(12'h000, 32'h0000_0006);
		chk(12'h020, 32'h0000_0001);
		CTL.wr(12'h000, 32'h0000_0002);
		chk(12'h020, 32'h0000_0000);
		results();
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		$display("MISMATCH t=%0t run took too long", $time);
		results();
	end
endmodule
